// ===== include/sec_detect_pkg.sv
// Register map, field positions and carrier types of the secondary-channel and detect bank
package sec_detect_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_TEST_PATTERN = 8'h02;
   localparam logic [7:0] IDX_LONG_DETECT  = 8'h0c;
   localparam logic [7:0] IDX_SHORT_DETECT = 8'h0d;
   localparam logic [7:0] IDX_SEC_RX_BUF   = 8'h16;
   localparam logic [7:0] IDX_SEC_TX_BUF   = 8'h17;
   localparam logic [7:0] IDX_SEC_CTRL     = 8'h1a;
   localparam logic [7:0] IDX_LOOPBACK     = 8'h30;
   localparam logic [7:0] IDX_PATTERN_STAT = 8'h31;
   localparam logic [7:0] IDX_SYNC_TIMEOUT = 8'ha5;
   localparam logic [7:0] IDX_ERROR_COUNT  = 8'ha7;
   localparam logic [2:0] SIZE_WORD        = 3'h2;

   // Field positions
   localparam int BIT_SEND_PATTERN = 5;
   localparam int BIT_S_SEQ        = 3;
   localparam int BIT_S1           = 5;
   localparam int BIT_SCRAMBLED_ONES_FLAG         = 4;
   localparam int BIT_SEC_EN       = 0;
   localparam int BIT_IN_EMPTY     = 1;
   localparam int BIT_OUT_FULL     = 2;
   localparam int BIT_DET_ENABLE   = 7;
   localparam int BIT_LB_REQ       = 0;
   localparam int BIT_LB_DET_EN    = 4;
   localparam int PRBS_TAP_A       = 8;
   localparam int PRBS_TAP_B       = 4;

   // Values after reset
   localparam logic [7:0] RST_TEST_PATTERN = 8'h00;
   localparam logic [7:0] RST_LOOPBACK     = 8'h00;
   localparam logic [7:0] RST_SYNC_TIMEOUT = 8'h00;
   localparam logic       RST_SEC_EN       = 1'b0;
   localparam logic       RST_IN_EMPTY     = 1'b1;
   localparam logic       RST_OUT_FULL     = 1'b0;
   localparam logic [8:0] RST_PRBS_SEED    = 9'h1ff;

   // Counts
   localparam logic [3:0] SYNC_GOOD_BITS   = 4'h9;
   localparam logic [2:0] BYTE_BITS_LAST   = 3'h7;

   typedef enum logic [1:0] {
      FAM_OTHER  = 2'b00,
      FAM_V22BIS = 2'b01,
      FAM_V32    = 2'b10,
      FAM_V34    = 2'b11
   } modem_family_e;

   typedef enum logic [1:0] {
      TX_IDLE     = 2'b00,
      TX_PATTERN  = 2'b01,
      TX_LOOPBACK = 2'b10
   } tx_source_e;

   typedef struct packed {
      modem_family_e family;
      logic          rate_7200_up;
      logic          sync_mode;
      logic          idle;
      logic          handshake;
      logic          carrier_detect;
      logic          retrain;
   } pump_mode_s;

   typedef struct packed {
      logic s1;
      logic scrambled_ones;
      logic s_seq;
   } hs_detect_s;

   typedef struct packed {
      logic tick;
      logic data;
   } bit_strobe_s;
endpackage

// ===== verilog/sec_detect_bank.sv
// Secondary-channel buffers, handshake detect flags and 511 pattern control behind AHB-Lite
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
module sec_detect_bank
   import sec_detect_pkg::*;
(
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Pump state
   input  pump_mode_s       pump_mode,
   input  hs_detect_s       hs_detect,
   // Test pattern bit streams
   input  bit_strobe_s      tx_bit,
   input  bit_strobe_s      rx_bit,
   output tx_source_e       tx_source,
   output logic             pattern_bit,
   output logic [2:0]       loopback_req,
   // Secondary channel
   input  wire logic        sec_tx_take,
   input  wire logic        sec_rx_load,
   input  wire logic [7:0]  sec_rx_data,
   output logic             sec_tx_valid,
   output logic [7:0]       sec_tx_data,
   output logic             sec_active
);

   // Bus phase tracking
   logic        wr_pend_r;
   logic        rd_wait_r;
   logic        map_r;
   logic [7:0]  idx_r;
   logic [31:0] hrdata_r;

   wire        acc_req = hsel && htrans[1] && hready && (hsize == SIZE_WORD);
   wire        map_nxt = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
   wire [7:0]  idx_nxt = haddr[9:2];

   function automatic logic wr_at(input logic [7:0] want);
      wr_at = wr_pend_r && map_r && (idx_r == want);
   endfunction

   function automatic logic prbs_fb(input logic [8:0] s);
      prbs_fb = s[PRBS_TAP_A] ^ s[PRBS_TAP_B];
   endfunction

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         rd_wait_r <= 1'b0;
         map_r     <= 1'b0;
         idx_r     <= 8'h00;
      end else begin
         wr_pend_r <= acc_req && hwrite;
         rd_wait_r <= acc_req && !hwrite;
         if (acc_req) begin
            map_r <= map_nxt;
            idx_r <= idx_nxt;
         end
      end
   end

   // Software registers
   logic [7:0] test_ctrl_r;
   logic [7:0] loopback_r;
   logic [7:0] sync_timeout_r;
   logic [7:0] tx_buf_r;
   logic [7:0] rx_buf_r;
   logic       sec_en_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         test_ctrl_r    <= RST_TEST_PATTERN;
         loopback_r     <= RST_LOOPBACK;
         sync_timeout_r <= RST_SYNC_TIMEOUT;
         tx_buf_r       <= 8'h00;
         sec_en_r       <= RST_SEC_EN;
      end else begin
         if (wr_at(IDX_TEST_PATTERN))
            test_ctrl_r <= hwdata[7:0];
         if (wr_at(IDX_LOOPBACK))
            loopback_r <= hwdata[7:0];
         if (wr_at(IDX_SYNC_TIMEOUT))
            sync_timeout_r <= hwdata[7:0];
         if (wr_at(IDX_SEC_TX_BUF))
            tx_buf_r <= hwdata[7:0];
         if (wr_at(IDX_SEC_CTRL))
            sec_en_r <= hwdata[BIT_SEC_EN];
      end
   end

   // Handshake detector flags, set and cleared by the pump
   logic s1_r;
   logic scrambled_ones_flag_r;
   logic s_seq_r;

   wire is_v22 = (pump_mode.family == FAM_V22BIS);
   wire is_v3x = (pump_mode.family == FAM_V32) || (pump_mode.family == FAM_V34);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_r    <= 1'b0;
         scrambled_ones_flag_r  <= 1'b0;
         s_seq_r <= 1'b0;
      end else begin
         s1_r    <= hs_detect.s1 && is_v22;
         scrambled_ones_flag_r  <= hs_detect.scrambled_ones && is_v22;
         s_seq_r <= hs_detect.s_seq && is_v3x;
      end
   end

   // Secondary channel buffers and flags
   logic in_empty_r;
   logic out_full_r;
   logic tx_pending_r;
   logic sec_active_r;

   // Spelled out: a continuous assignment does not see what a function reads beyond its arguments
   wire wr_sec    = wr_pend_r && map_r && (idx_r == IDX_SEC_CTRL);
   wire wr_txb    = wr_pend_r && map_r && (idx_r == IDX_SEC_TX_BUF);
   wire take_ok   = sec_tx_take && tx_pending_r && sec_active_r;
   wire supported = (pump_mode.family == FAM_V34) ||
                    ((pump_mode.family == FAM_V32) && pump_mode.rate_7200_up);
   // Idle, handshake before carrier detect, or a retrain
   wire apply_win = pump_mode.idle || pump_mode.retrain ||
                    (pump_mode.handshake && !pump_mode.carrier_detect);

   // Set wins over the host's write-zero clear
   wire in_empty_nxt   = take_ok ? 1'b1 :
                         (wr_sec && !hwdata[BIT_IN_EMPTY]) ? 1'b0 : in_empty_r;
   wire out_full_nxt   = sec_rx_load ? 1'b1 :
                         (wr_sec && !hwdata[BIT_OUT_FULL]) ? 1'b0 : out_full_r;
   wire tx_pending_nxt = wr_txb ? 1'b1 : (take_ok ? 1'b0 : tx_pending_r);
   wire sec_active_nxt = !supported ? 1'b0 :
                         (apply_win ? sec_en_r : sec_active_r);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         in_empty_r   <= RST_IN_EMPTY;
         out_full_r   <= RST_OUT_FULL;
         tx_pending_r <= 1'b0;
         sec_active_r <= 1'b0;
         rx_buf_r     <= 8'h00;
      end else begin
         in_empty_r   <= in_empty_nxt;
         out_full_r   <= out_full_nxt;
         tx_pending_r <= tx_pending_nxt;
         sec_active_r <= sec_active_nxt;
         if (sec_rx_load)
            rx_buf_r <= sec_rx_data;
      end
   end

   // 511 pattern transmit source selection
   tx_source_e tx_state_r;
   tx_source_e tx_state_nxt;
   logic [8:0] gen_r;
   logic       pattern_bit_r;

   wire lb_any     = |loopback_r[BIT_LB_REQ +: 3];
   wire pattern_on = test_ctrl_r[BIT_SEND_PATTERN] && pump_mode.sync_mode;

   always_comb begin
      case (tx_state_r)
         TX_IDLE:     tx_state_nxt = pattern_on ? TX_PATTERN : TX_IDLE;
         TX_PATTERN:  tx_state_nxt = !pattern_on ? TX_IDLE :
                                     (lb_any ? TX_LOOPBACK : TX_PATTERN);
         TX_LOOPBACK: tx_state_nxt = lb_any ? TX_LOOPBACK :
                                     (pattern_on ? TX_PATTERN : TX_IDLE);
         default:     tx_state_nxt = TX_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_state_r    <= TX_IDLE;
         gen_r         <= RST_PRBS_SEED;
         pattern_bit_r <= 1'b0;
      end else begin
         tx_state_r <= tx_state_nxt;
         // Generator holds its state while paused, so the pattern resumes
         if (tx_state_r == TX_PATTERN && tx_bit.tick) begin
            gen_r         <= {gen_r[7:0], prbs_fb(gen_r)};
            pattern_bit_r <= prbs_fb(gen_r);
         end
      end
   end

   // 511 pattern detector
   logic [8:0]  chk_r;
   logic [3:0]  good_r;
   logic [2:0]  bit_cnt_r;
   logic [6:0]  byte_cnt_r;
   logic        in_sync_r;
   logic        timeout_r;
   logic [15:0] err_cnt_r;

   wire       det_on    = sync_timeout_r[BIT_DET_ENABLE] && pump_mode.sync_mode &&
                          !(|loopback_r[BIT_LB_DET_EN +: 3]);
   wire [6:0] tmo_limit = sync_timeout_r[6:0];
   wire       rx_step   = det_on && rx_bit.tick;
   wire       rx_miss   = rx_bit.data != prbs_fb(chk_r);
   wire       byte_done = rx_step && (bit_cnt_r == BYTE_BITS_LAST);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chk_r      <= 9'h000;
         good_r     <= 4'h0;
         bit_cnt_r  <= 3'h0;
         byte_cnt_r <= 7'h00;
         in_sync_r  <= 1'b0;
         timeout_r  <= 1'b0;
      end else if (!det_on) begin
         good_r     <= 4'h0;
         bit_cnt_r  <= 3'h0;
         byte_cnt_r <= 7'h00;
         in_sync_r  <= 1'b0;
         timeout_r  <= 1'b0;
      end else if (rx_step) begin
         chk_r     <= {chk_r[7:0], rx_bit.data};
         bit_cnt_r <= bit_cnt_r + 3'h1;
         if (!in_sync_r) begin
            good_r <= rx_miss ? 4'h0 : good_r + 4'h1;
            if (!rx_miss && good_r == SYNC_GOOD_BITS - 4'h1)
               in_sync_r <= 1'b1;
         end
         // Timeout counted in whole byte times while unsynchronised
         if (byte_done && !in_sync_r && !timeout_r) begin
            if (byte_cnt_r == tmo_limit)
               timeout_r <= 1'b1;
            else
               byte_cnt_r <= byte_cnt_r + 7'h01;
         end
      end
   end

   // Error count restarts when a new timeout setting is written
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         err_cnt_r <= 16'h0000;
      else if (wr_at(IDX_SYNC_TIMEOUT))
         err_cnt_r <= 16'h0000;
      else if (rx_step && in_sync_r && rx_miss && err_cnt_r != 16'hffff)
         err_cnt_r <= err_cnt_r + 16'h0001;
   end

   // Read data selection
   wire [7:0]  long_stat  = 8'(s_seq_r) << BIT_S_SEQ;
   wire [7:0]  short_stat = (8'(s1_r) << BIT_S1) | (8'(scrambled_ones_flag_r) << BIT_SCRAMBLED_ONES_FLAG);
   wire [7:0]  sec_stat   = (8'(sec_en_r) << BIT_SEC_EN) | (8'(in_empty_r) << BIT_IN_EMPTY) |
                            (8'(out_full_r) << BIT_OUT_FULL);
   wire [7:0]  patt_stat  = {5'h00, sec_active_r, timeout_r, in_sync_r};
   wire [15:0] rd_byte    = (idx_r == IDX_TEST_PATTERN) ? {8'h00, test_ctrl_r}    :
                            (idx_r == IDX_LONG_DETECT)  ? {8'h00, long_stat}      :
                            (idx_r == IDX_SHORT_DETECT) ? {8'h00, short_stat}     :
                            (idx_r == IDX_SEC_RX_BUF)   ? {8'h00, rx_buf_r}       :
                            (idx_r == IDX_SEC_TX_BUF)   ? {8'h00, tx_buf_r}       :
                            (idx_r == IDX_SEC_CTRL)     ? {8'h00, sec_stat}       :
                            (idx_r == IDX_LOOPBACK)     ? {8'h00, loopback_r}     :
                            (idx_r == IDX_PATTERN_STAT) ? {8'h00, patt_stat}      :
                            (idx_r == IDX_SYNC_TIMEOUT) ? {8'h00, sync_timeout_r} :
                            (idx_r == IDX_ERROR_COUNT)  ? err_cnt_r               : 16'h0000;
   wire [31:0] rd_data    = map_r ? {16'h0000, rd_byte} : 32'h0000_0000;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hrdata_r <= 32'h0000_0000;
      else if (rd_wait_r)
         hrdata_r <= rd_data;
   end

   // Outputs
   assign hreadyout    = !rd_wait_r;
   assign hresp        = 1'b0;
   assign hrdata       = hrdata_r;
   assign tx_source    = tx_state_r;
   assign pattern_bit  = pattern_bit_r;
   assign loopback_req = loopback_r[BIT_LB_REQ +: 3];
   assign sec_tx_valid = tx_pending_r && sec_active_r;
   assign sec_tx_data  = tx_buf_r;
   assign sec_active   = sec_active_r;

   // Checks
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   AST_S1_FLAG: assert property ((hs_detect.s1 && is_v22) |=> s1_r ##1 (s1_r || !$past(hs_detect.s1 && is_v22)))
      else $error("s1 flag did not follow detection");
   AST_SCRAMBLED_ONES_FLAG_FLAG: assert property (!hs_detect.scrambled_ones |=> !scrambled_ones_flag_r)
      else $error("scrambled ones flag not cleared at sequence end");
   AST_S_SEQ_FLAG: assert property (s_seq_r |-> $past(is_v3x && hs_detect.s_seq))
      else $error("s sequence flag set outside its modes");
   AST_PATTERN_START: assert property ((tx_state_r == TX_IDLE && pattern_on) |=> tx_state_r == TX_PATTERN)
      else $error("pattern did not start");
   AST_LOOPBACK_HOLD: assert property ((tx_state_r == TX_LOOPBACK) |=> $stable(gen_r))
      else $error("generator advanced during loopback pause");
   AST_LOOPBACK_RESUME: assert property ((tx_state_r == TX_LOOPBACK && !lb_any && pattern_on)
                                         |=> tx_state_r == TX_PATTERN)
      else $error("pattern did not resume after loopback");
   AST_ERR_COUNT: assert property ((rx_step && in_sync_r && rx_miss && err_cnt_r != 16'hffff
                                    && !wr_at(IDX_SYNC_TIMEOUT)) |=> err_cnt_r == $past(err_cnt_r) + 16'h0001)
      else $error("error count did not advance");
   AST_MAX_TIMEOUT: assert property ((sync_timeout_r == 8'hff && pump_mode.sync_mode && loopback_r[6:4] == 3'h0)
                                     |-> det_on && tmo_limit == 7'h7f)
      else $error("all-ones timeout not taken as enable with maximum");
   AST_EMPTY_AFTER_TAKE: assert property ($rose(in_empty_r) |-> $past(take_ok))
      else $error("input empty set without a byte taken");
   AST_EMPTY_SET: assert property (take_ok |=> in_empty_r ##1 1'b1)
      else $error("input empty not set after take");
   AST_FULL_ON_LOAD: assert property (sec_rx_load |=> out_full_r && rx_buf_r == $past(sec_rx_data))
      else $error("receive byte not held with full flag");
   AST_SEC_SUPPORT: assert property (!supported |=> !sec_active_r)
      else $error("secondary channel active in unsupported mode");
   AST_SEC_APPLY: assert property ((apply_win && supported) |=> sec_active_r == $past(sec_en_r))
      else $error("secondary enable not applied");
   AST_READ_WAIT: assert property ((acc_req && !hwrite) |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");

   COV_PAUSE: cover property (tx_state_r == TX_PATTERN ##1 tx_state_r == TX_LOOPBACK ##1 tx_state_r == TX_PATTERN);
   COV_TX_BYTE: cover property (wr_at(IDX_SEC_TX_BUF) ##[1:20] take_ok);
   COV_RX_BYTE: cover property (sec_rx_load ##1 out_full_r);
   COV_SYNC: cover property ($rose(in_sync_r));

endmodule

// ===== bench/pump_model.sv
// Behavioural pump side: bit ticks, secondary byte take and receive loads
`timescale 1ns/1ps
module pump_model
   import sec_detect_pkg::*;
(
   // Clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // Bench control
   input  wire logic       take_en,
   input  wire logic       rx_req,
   input  wire logic [7:0] rx_byte,
   // Device side
   input  wire logic       sec_tx_valid,
   input  wire logic [7:0] sec_tx_data,
   input  wire logic       pattern_bit,
   output bit_strobe_s     tx_bit,
   output bit_strobe_s     rx_bit,
   output logic            sec_tx_take,
   output logic            sec_rx_load,
   output logic [7:0]      sec_rx_data,
   output logic [7:0]      taken
);
   logic [1:0] cnt_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r <= 2'h0;
         tx_bit <= '0;
         rx_bit <= '0;
         sec_tx_take <= 1'b0;
         sec_rx_load <= 1'b0;
         sec_rx_data <= 8'h00;
         taken <= 8'h00;
      end else begin
         cnt_r <= cnt_r + 2'h1;
         tx_bit <= '{cnt_r == 2'h3, cnt_r[0]};
         // Own pattern looped back, sampled after it settles
         rx_bit <= '{cnt_r == 2'h1, pattern_bit};
         sec_tx_take <= take_en & sec_tx_valid & !sec_tx_take;
         if (sec_tx_take) begin
            taken <= sec_tx_data;
         end
         sec_rx_load <= rx_req;
         // Idle data never repeats the last byte
         sec_rx_data <= rx_req ? rx_byte : ~sec_rx_data;
      end
   end
endmodule

// ===== bench/testbench.sv
// Self-checking testbench of the secondary-channel and detect bank
`timescale 1ns/1ps
module testbench
   import sec_detect_pkg::*;
;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   pump_mode_s  pump_mode;
   hs_detect_s  hs_detect;
   bit_strobe_s tx_bit;
   bit_strobe_s rx_bit;
   tx_source_e  tx_source;
   logic        pattern_bit;
   logic [2:0]  loopback_req;
   logic        sec_tx_take;
   logic        sec_rx_load;
   logic        sec_tx_valid;
   logic        sec_active;
   logic [7:0]  sec_rx_data;
   logic [7:0]  sec_tx_data;
   logic [7:0]  taken;
   logic [7:0]  rx_byte = 8'h00;
   logic        rx_req = 1'b0;
   logic        take_en = 1'b0;
   logic [31:0] r;
   logic [31:0] rv;
   int          miscompares = 0;
   int          checks_done = 0;
   int          n;
   integer      seed = 32'h3b14;

   always #25 hclk = ~hclk;

   sec_detect_bank dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .pump_mode(pump_mode), .hs_detect(hs_detect), .tx_bit(tx_bit),
      .rx_bit(rx_bit), .tx_source(tx_source), .pattern_bit(pattern_bit), .loopback_req(loopback_req),
      .sec_tx_take(sec_tx_take), .sec_rx_load(sec_rx_load), .sec_rx_data(sec_rx_data),
      .sec_tx_valid(sec_tx_valid), .sec_tx_data(sec_tx_data), .sec_active(sec_active));

   pump_model partner (.hclk(hclk), .hresetn(hresetn), .take_en(take_en), .rx_req(rx_req),
      .rx_byte(rx_byte), .sec_tx_valid(sec_tx_valid), .sec_tx_data(sec_tx_data),
      .pattern_bit(pattern_bit), .tx_bit(tx_bit), .rx_bit(rx_bit), .sec_tx_take(sec_tx_take),
      .sec_rx_load(sec_rx_load), .sec_rx_data(sec_rx_data), .taken(taken));

   task stop_test;
      $display("miscompares=%0d checks_done=%0d", miscompares, checks_done);
      if (miscompares == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // One single AHB transfer; rv holds the read data
   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      int k;
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      hsize <= SIZE_WORD;
      k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (hreadyout !== 1'b1 && k < 50);
      if (hreadyout !== 1'b1) begin
         miscompares++;
         $display("mismatch at %0t: bus address phase timeout", $time);
         stop_test();
      end
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do begin
         @(posedge hclk);
         k++;
      end while (hreadyout !== 1'b1 && k < 100);
      rv = hrdata;
      if (hreadyout !== 1'b1) begin
         miscompares++;
         $display("mismatch at %0t: bus data phase timeout", $time);
         stop_test();
      end
   endtask

   task wr(input logic [31:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task rd(input logic [31:0] a, input logic [31:0] exp, input string what);
      bus(1'b0, a, 32'h0);
      chk(rv, exp, what);
   endtask

   task cyc(input int k);
      repeat (k) @(posedge hclk);
   endtask

   task retrain;
      pump_mode.retrain <= 1'b1;
      cyc(1);
      pump_mode.retrain <= 1'b0;
      cyc(3);
   endtask

   function automatic logic [31:0] exp_short(logic [1:0] fam, logic [2:0] hs);
      return {26'h0, (fam == 2'b01) & hs[2], (fam == 2'b01) & hs[1], 4'h0};
   endfunction

   function automatic logic [31:0] exp_long(logic [1:0] fam, logic [2:0] hs);
      return {28'h0, fam[1] & hs[0], 3'h0};
   endfunction

   initial begin
      pump_mode = '{FAM_V34, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
      hs_detect = '0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(32'h68, 32'h02, "control reset");
      rd(32'h08, 32'h00, "pattern control reset");
      rd(32'h29c, 32'h00, "error count reset");
      wr(32'h3fc, 32'hff);
      rd(32'h3fc, 32'h00, "unmapped read");
      for (int i = 0; i < 24; i++) begin
         r = $random(seed);
         pump_mode.family <= modem_family_e'(r[1:0]);
         hs_detect <= hs_detect_s'(r[4:2]);
         cyc(2);
         rd(32'h34, exp_short(r[1:0], r[4:2]), "short detect");
         rd(32'h30, exp_long(r[1:0], r[4:2]), "long detect");
      end
      pump_mode.family <= FAM_V34;
      wr(32'h68, 32'h07);
      cyc(3);
      chk(sec_active, 1, "enable in idle");
      pump_mode.idle <= 1'b0;
      pump_mode.carrier_detect <= 1'b1;
      wr(32'h68, 32'h06);
      cyc(3);
      chk(sec_active, 1, "data mode holds");
      retrain();
      chk(sec_active, 0, "retrain off");
      wr(32'h68, 32'h07);
      retrain();
      chk(sec_active, 1, "retrain on");
      pump_mode.handshake <= 1'b1;
      pump_mode.carrier_detect <= 1'b0;
      wr(32'h68, 32'h06);
      cyc(3);
      chk(sec_active, 0, "early handshake off");
      wr(32'h68, 32'h07);
      cyc(3);
      chk(sec_active, 1, "early handshake on");
      pump_mode.carrier_detect <= 1'b1;
      pump_mode.family <= FAM_V32;
      pump_mode.rate_7200_up <= 1'b0;
      cyc(3);
      chk(sec_active, 0, "low rate");
      pump_mode.rate_7200_up <= 1'b1;
      retrain();
      chk(sec_active, 1, "high rate");
      for (int i = 0; i < 4; i++) begin
         r = $random(seed);
         take_en <= 1'b0;
         wr(32'h5c, {24'h0, r[7:0]});
         wr(32'h68, 32'h05);
         rd(32'h68, 32'h01, "empty cleared, pump stalled");
         chk(sec_tx_data, r[7:0], "tx byte");
         take_en <= 1'b1;
         for (n = 0; n < 20 && sec_tx_valid !== 1'b0; n++) cyc(1);
         chk(n < 20, 1, "byte taken");
         cyc(1);
         rd(32'h68, 32'h03, "empty set again");
         chk(taken, r[7:0], "pump got byte");
      end
      for (int i = 0; i < 4; i++) begin
         r = $random(seed);
         rx_byte <= r[7:0];
         rx_req <= 1'b1;
         cyc(1);
         rx_req <= 1'b0;
         cyc(3);
         rd(32'h68, 32'h07, "full set");
         rd(32'h58, {24'h0, r[7:0]}, "rx byte");
         wr(32'h68, 32'h03);
         rd(32'h68, 32'h03, "full cleared");
      end
      wr(32'h294, 32'hff);
      rd(32'h294, 32'hff, "sync timeout");
      wr(32'h08, 32'h20);
      cyc(2);
      chk(tx_source, TX_PATTERN, "pattern on");
      cyc(150);
      rd(32'hc4, 32'h05, "detector in sync");
      rd(32'h29c, 32'h00, "no errors");
      for (int i = 0; i < 3; i++) begin
         wr(32'hc0, 32'h1 << i);
         cyc(2);
         chk(tx_source, TX_LOOPBACK, "loopback");
         chk(loopback_req, 3'h1 << i, "request");
         wr(32'hc0, 32'h0);
         cyc(2);
         chk(tx_source, TX_PATTERN, "resume");
         wr(32'hc0, 32'h10 << i);
         cyc(2);
         rd(32'hc4, 32'h04, "detect off");
      end
      wr(32'h08, 32'h00);
      cyc(2);
      chk(tx_source, TX_IDLE, "pattern off");
      stop_test();
   end
endmodule
